/* bench/cfg_bank_props.sv */
// Port assertions for the charger settings register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_props (
    input wire logic ref_clk_i, rst_i, wr_en_i, rd_en_i, watchdog_enabled_i, charger_enabled_i,
    input wire logic battery_warm_threshold_i, watchdog_restart_o, settings_unlocked_o,
    input wire logic thermal_reg_flag_o, current_foldback_o,
    input wire logic [7:0] addr_i, wdata_i, junction_temp_i, rdata_o, temp_setpoint_c_o,
    input wire logic [5:0] charge_term_voltage_o,
    input wire logic [12:0] charge_target_mv_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Qualified watchdog clear write
    wire clr = wr_en_i && addr_i == 8'hBD && wdata_i[1:0] == 2'h1 && watchdog_enabled_i;
    // Temperature and setpoint both held long enough for the flag to settle
    sequence s_quiet;
        ($stable(junction_temp_i) && $stable(temp_setpoint_c_o))[*6];
    endsequence
    property p_wd; clr |=> watchdog_restart_o; endproperty
    a_wd: assert property (p_wd) else $error("restart pulse missing");
    property p_nowd; !clr |=> !watchdog_restart_o; endproperty
    a_nowd: assert property (p_nowd) else $error("restart pulse without clear");
    property p_unl; wr_en_i && addr_i == 8'hBD |=> ##1 settings_unlocked_o == $past(wdata_i[3:2] == 2'h3, 2); endproperty
    a_unl: assert property (p_unl) else $error("unlock state wrong");
    property p_fold; thermal_reg_flag_o == current_foldback_o; endproperty
    a_fold: assert property (p_fold) else $error("foldback differs from flag");
    property p_flag; s_quiet |-> thermal_reg_flag_o == (junction_temp_i > temp_setpoint_c_o); endproperty
    a_flag: assert property (p_flag) else $error("thermal flag wrong");
    property p_rd; rd_en_i && !(addr_i inside {8'hBB, 8'hBD, 8'hBE}) |=> rdata_o == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("unmapped read not zero");
    property p_lock; wr_en_i && addr_i == 8'hBB && !settings_unlocked_o && !$past(wr_en_i && addr_i == 8'hBD) |=> ##1 $stable(charge_term_voltage_o); endproperty
    a_lock: assert property (p_lock) else $error("locked write took effect");
    property p_tgt; (!charger_enabled_i || battery_warm_threshold_i)[*4] |-> charge_target_mv_o == 12'h000; endproperty
    a_tgt: assert property (p_tgt) else $error("target applied while inactive");
endmodule // cfg_bank_props
bind charger_config_protect_regs cfg_bank_props u_props (.*);
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the charger settings register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk_i = 0, rst_i = 1, wr_en_i = 0, rd_en_i = 0, watchdog_enabled_i = 1;
    logic charger_enabled_i = 1, battery_warm_threshold_i = 0, watchdog_restart_o;
    logic settings_unlocked_o, thermal_reg_flag_o, current_foldback_o;
    logic [7:0] addr_i = 0, wdata_i = 0, junction_temp_i = 8'h19, rdata_o, temp_setpoint_c_o;
    logic [5:0] charge_term_voltage_o;
    logic [12:0] charge_target_mv_o;
    logic [11:0] min_system_mv_o;
    logic [5:0] cw [4] = '{6'h00, 6'h1C, 6'h1D, 6'h2B};
    int n_mismatch = 0, cmp_count = 0;
    charger_config_protect_regs uut (.*);
    // 20 MHz clock
    initial forever #25 ref_clk_i = ~ref_clk_i;
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // One register access, write or read, then settle
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_en_i <= w;
        rd_en_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_en_i <= 1'h0;
        rd_en_i <= 1'h0;
        #1;
    endtask
    task automatic chk(input string s, input logic [12:0] e, input logic [12:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h00);
        chk("rdata", {5'h00, e}, {5'h00, rdata_o});
    endtask
    // Termination voltage in mV for a field code
    function automatic logic [12:0] mv(input logic [5:0] c);
        if (c < 6'h1C) return 13'h0E42 + 13'(c) * 13'h0019;
        return (c == 6'h1C) ? 13'h10F4 : 13'h10FE + 13'(c - 6'h1D) * 13'h0019;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        tick(2);
        chk("target", 13'h1068, charge_target_mv_o);
        chk("minsys", 13'h0E10, {1'h0, min_system_mv_o});
        chk("setpt", 13'h0073, {5'h00, temp_setpoint_c_o});
        chk("code", 13'h0016, {7'h00, charge_term_voltage_o});
        rdc(8'hBB, 8'h96);
        rdc(8'hBD, 8'h00);
        rdc(8'hBE, 8'h40);
        acc(1'h1, 8'hBB, 8'h1C);
        rdc(8'hBB, 8'h96);
        $display("test reset_and_lock done");
        acc(1'h1, 8'hBD, 8'h0D);
        chk("restart", 13'h0001, {12'h000, watchdog_restart_o});
        tick(1);
        chk("unlocked", 13'h0001, {12'h000, settings_unlocked_o});
        for (int i = 0; i < 4; i++) begin
            acc(1'h1, 8'hBB, {i[1:0], cw[i]});
            tick(1);
            chk("target", mv(cw[i]), charge_target_mv_o);
            chk("code", {7'h00, cw[i]}, {7'h00, charge_term_voltage_o});
            chk("minsys", 13'h0D48 + 13'(i) * 13'h0064, {1'h0, min_system_mv_o});
            acc(1'h1, 8'hBE, {1'h1, i[1:0], 5'h1F});
            tick(1);
            chk("setpt", 13'h0055 + 13'(i) * 13'h000F, {5'h00, temp_setpoint_c_o});
            rdc(8'hBE, {1'h0, i[1:0], 5'h00});
            @(posedge ref_clk_i);
            junction_temp_i <= 8'h56 + 8'(i) * 8'h0F;
            tick(4);
            chk("flag", 13'h0003, {11'h000, thermal_reg_flag_o, current_foldback_o});
            @(posedge ref_clk_i);
            junction_temp_i <= 8'h55 + 8'(i) * 8'h0F;
            tick(4);
            chk("flag", 13'h0000, {11'h000, thermal_reg_flag_o, current_foldback_o});
        end
        $display("test decode_and_thermal done");
        acc(1'h1, 8'hBD, 8'hF6);
        chk("restart", 13'h0000, {12'h000, watchdog_restart_o});
        rdc(8'hBD, 8'h06);
        acc(1'h1, 8'hBE, 8'h00);
        rdc(8'hBE, 8'h60);
        rdc(8'h00, 8'h00);
        @(posedge ref_clk_i);
        battery_warm_threshold_i <= 1'h1;
        tick(4);
        chk("target", 13'h0000, charge_target_mv_o);
        @(posedge ref_clk_i);
        battery_warm_threshold_i <= 1'h0;
        tick(4);
        chk("target", 13'h125C, charge_target_mv_o);
        @(posedge ref_clk_i);
        charger_enabled_i <= 1'h0;
        tick(2);
        chk("target", 13'h0000, charge_target_mv_o);
        @(posedge ref_clk_i);
        charger_enabled_i <= 1'h1;
        watchdog_enabled_i <= 1'h0;
        acc(1'h1, 8'hBD, 8'h01);
        chk("restart", 13'h0000, {12'h000, watchdog_restart_o});
        @(posedge ref_clk_i);
        watchdog_enabled_i <= 1'h1;
        $display("test relock_and_enables done");
        acc(1'h1, 8'hBD, 8'h0C);
        tick(1);
        chk("unlocked", 13'h0001, {12'h000, settings_unlocked_o});
        @(posedge ref_clk_i);
        rst_i <= 1'h1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        tick(2);
        chk("unlocked", 13'h0000, {12'h000, settings_unlocked_o});
        rdc(8'hBD, 8'h00);
        rdc(8'hBB, 8'h96);
        rdc(8'hBE, 8'h40);
        $display("test midrun_reset done");
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire

/* rtl/charger_config_protect_regs.v */
// Charger settings register bank with write protection and watchdog clear
`timescale 1ns/1ps
`default_nettype none
`include "charger_config_protect_regs.vh"

// Contract
// R1 - Key 11 at bits 3:2 unlocks; else locks
// R2 - Protected registers writable only while unlocked
// R3 - Key resets to 00, locked after reset
// R4 - Writing 01 at bits 1:0 restarts watchdog
// R5 - Six-bit termination voltage decode, reset 4.2V
// R6 - Apply target only when enabled, below warm
// R7 - Min system voltage 3.4 to 3.7V, reset 10
// R8 - Junction setpoint 85 to 130C, reset 10
// R9 - Above setpoint: set flag, fold back current
// R10 - Reserved bits reset zero, ignore writes
module charger_config_protect_regs (
    input wire ref_clk_i, // 20 MHz clock
    input wire rst_i, // Synchronous reset, active high
    input wire wr_en_i, // Register write strobe
    input wire rd_en_i, // Register read strobe
    input wire [7:0] addr_i, // Register address
    input wire [7:0] wdata_i, // Write data
    input wire watchdog_enabled_i, // Watchdog timer enabled
    input wire charger_enabled_i, // Charger enabled
    input wire battery_warm_threshold_i, // Battery at or above warm threshold (pin)
    input wire [7:0] junction_temp_i, // Junction temperature, degrees C (pin)
    output reg [7:0] rdata_o, // Read data
    output reg watchdog_restart_o, // One-cycle watchdog restart pulse
    output reg settings_unlocked_o, // Protected registers writable
    output reg [5:0] charge_term_voltage_o, // Termination voltage code
    output reg [12:0] charge_target_mv_o, // Applied charge target in mV, 0 when inactive
    output reg [11:0] min_system_mv_o, // Minimum system voltage in mV
    output reg [7:0] temp_setpoint_c_o, // Selected junction setpoint in C
    output reg thermal_reg_flag_o, // Junction above setpoint
    output reg current_foldback_o // Charger current fold back request
);

    reg [7:0] charge_voltage_config;
    reg [7:0] watchdog_and_protect_control;
    reg [7:0] thermal_regulation_config;
    reg warm_meta, warm_sync;
    reg [7:0] temp_meta, temp_sync;
    reg [7:0] next_rdata;
    wire unlocked;
    wire [12:0] term_mv; // Up to 4700 mV needs 13 bits
    wire [11:0] min_sys_mv;
    wire [7:0] setpoint_c;
    wire over_setpoint;

    // Termination voltage code to mV: 25 mV steps with the 4.340/4.350 kink,
    // codes above the table top hold at the highest target
    function [12:0] term_volt_mv;
        input [5:0] code;
        begin
            case (code) // R5
                6'h00: term_volt_mv = 13'h0E42;
                6'h01: term_volt_mv = 13'h0E5B;
                6'h02: term_volt_mv = 13'h0E74;
                6'h03: term_volt_mv = 13'h0E8D;
                6'h04: term_volt_mv = 13'h0EA6;
                6'h05: term_volt_mv = 13'h0EBF;
                6'h06: term_volt_mv = 13'h0ED8;
                6'h07: term_volt_mv = 13'h0EF1;
                6'h08: term_volt_mv = 13'h0F0A;
                6'h09: term_volt_mv = 13'h0F23;
                6'h0A: term_volt_mv = 13'h0F3C;
                6'h0B: term_volt_mv = 13'h0F55;
                6'h0C: term_volt_mv = 13'h0F6E;
                6'h0D: term_volt_mv = 13'h0F87;
                6'h0E: term_volt_mv = 13'h0FA0;
                6'h0F: term_volt_mv = 13'h0FB9;
                6'h10: term_volt_mv = 13'h0FD2;
                6'h11: term_volt_mv = 13'h0FEB;
                6'h12: term_volt_mv = 13'h1004;
                6'h13: term_volt_mv = 13'h101D;
                6'h14: term_volt_mv = 13'h1036;
                6'h15: term_volt_mv = 13'h104F;
                6'h16: term_volt_mv = 13'h1068;
                6'h17: term_volt_mv = 13'h1081;
                6'h18: term_volt_mv = 13'h109A;
                6'h19: term_volt_mv = 13'h10B3;
                6'h1A: term_volt_mv = 13'h10CC;
                6'h1B: term_volt_mv = 13'h10E5;
                6'h1C: term_volt_mv = 13'h10F4;
                6'h1D: term_volt_mv = 13'h10FE;
                6'h1E: term_volt_mv = 13'h1117;
                6'h1F: term_volt_mv = 13'h1130;
                6'h20: term_volt_mv = 13'h1149;
                6'h21: term_volt_mv = 13'h1162;
                6'h22: term_volt_mv = 13'h117B;
                6'h23: term_volt_mv = 13'h1194;
                6'h24: term_volt_mv = 13'h11AD;
                6'h25: term_volt_mv = 13'h11C6;
                6'h26: term_volt_mv = 13'h11DF;
                6'h27: term_volt_mv = 13'h11F8;
                6'h28: term_volt_mv = 13'h1211;
                6'h29: term_volt_mv = 13'h122A;
                6'h2A: term_volt_mv = 13'h1243;
                6'h2B: term_volt_mv = 13'h125C;
                default: term_volt_mv = 13'h125C;
            endcase
        end
    endfunction

    // Minimum system voltage code to mV, 100 mV steps from 3.4 V
    function [11:0] min_sys_mv_of;
        input [1:0] code;
        begin
            case (code) // R7
                2'h0: min_sys_mv_of = 12'hD48;
                2'h1: min_sys_mv_of = 12'hDAC;
                2'h2: min_sys_mv_of = 12'hE10;
                2'h3: min_sys_mv_of = 12'hE74;
                default: min_sys_mv_of = 12'hD48;
            endcase
        end
    endfunction

    // Junction setpoint code to degrees C, 15 C steps from 85 C
    function [7:0] setpoint_c_of;
        input [1:0] code;
        begin
            case (code) // R8
                2'h0: setpoint_c_of = 8'h55;
                2'h1: setpoint_c_of = 8'h64;
                2'h2: setpoint_c_of = 8'h73;
                2'h3: setpoint_c_of = 8'h82;
                default: setpoint_c_of = 8'h55;
            endcase
        end
    endfunction

    // Key decode and field decodes from the live register contents
    assign unlocked = (watchdog_and_protect_control[`UNLOCK_KEY_HI:`UNLOCK_KEY_LO]
        == `UNLOCK_KEY_VALUE); // R1
    assign term_mv = term_volt_mv(charge_voltage_config[`TERM_VOLT_HI:`TERM_VOLT_LO]);
    assign min_sys_mv = min_sys_mv_of(charge_voltage_config[`MIN_SYS_HI:`MIN_SYS_LO]); // R7
    assign setpoint_c =
        setpoint_c_of(thermal_regulation_config[`JT_SETPOINT_HI:`JT_SETPOINT_LO]); // R8
    // One compare feeds both flag and foldback so they can never disagree
    assign over_setpoint = (temp_sync > setpoint_c); // R9

    // Two-flop synchronisers for pin inputs
    // Temperature word must be quasi-static; a changing word may mis-sample once
    always @(posedge ref_clk_i) begin
        warm_meta <= battery_warm_threshold_i;
        warm_sync <= warm_meta;
        temp_meta <= junction_temp_i;
        temp_sync <= temp_meta;
    end

    // Register writes
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            charge_voltage_config <= `RST_CHARGE_VOLTAGE_CONFIG; // R5 R7
            watchdog_and_protect_control <= `RST_WATCHDOG_PROTECT_CTRL; // R3
            thermal_regulation_config <= `RST_THERMAL_REG_CONFIG; // R8 R10
            watchdog_restart_o <= 1'b0;
        end else begin
            watchdog_restart_o <= 1'b0;
            if (wr_en_i) begin
                case (addr_i)
                    `ADDR_CHARGE_VOLTAGE_CONFIG: begin
                        if (unlocked) begin
                            charge_voltage_config <= wdata_i & `CV_MASK; // R2
                        end
                    end
                    `ADDR_WATCHDOG_PROTECT_CTRL: begin
                        watchdog_and_protect_control <= wdata_i & `WP_MASK; // R1 R10
                        watchdog_restart_o <= watchdog_enabled_i &&
                            (wdata_i[`WDOG_CLEAR_HI:`WDOG_CLEAR_LO] == `WDOG_CLEAR_VALUE); // R4
                    end
                    `ADDR_THERMAL_REG_CONFIG: begin
                        if (unlocked) begin
                            thermal_regulation_config <= wdata_i & `TR_MASK; // R2 R10
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read multiplexer, unmapped addresses read zero
    always @* begin
        case (addr_i)
            `ADDR_CHARGE_VOLTAGE_CONFIG: next_rdata = charge_voltage_config;
            `ADDR_WATCHDOG_PROTECT_CTRL: next_rdata = watchdog_and_protect_control;
            `ADDR_THERMAL_REG_CONFIG: next_rdata = thermal_regulation_config;
            default: next_rdata = 8'h00;
        endcase
    end

    // Registered outputs
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            settings_unlocked_o <= 1'b0;
            charge_term_voltage_o <= 6'h00;
            charge_target_mv_o <= 13'h0000;
            min_system_mv_o <= 12'h000;
            temp_setpoint_c_o <= 8'h00;
            thermal_reg_flag_o <= 1'b0;
            current_foldback_o <= 1'b0;
        end else begin
            if (rd_en_i) begin
                rdata_o <= next_rdata;
            end
            settings_unlocked_o <= unlocked;
            charge_term_voltage_o <= charge_voltage_config[`TERM_VOLT_HI:`TERM_VOLT_LO];
            charge_target_mv_o <= (charger_enabled_i && !warm_sync) ? term_mv : 13'h0000; // R6
            min_system_mv_o <= min_sys_mv; // R7
            temp_setpoint_c_o <= setpoint_c; // R8
            thermal_reg_flag_o <= over_setpoint; // R9
            current_foldback_o <= over_setpoint; // R9
        end
    end

endmodule // charger_config_protect_regs
`default_nettype wire

/* rtl/charger_config_protect_regs.vh */
// Register map, field positions and reset values of the charger settings bank
`ifndef CHARGER_CONFIG_PROTECT_REGS_VH
`define CHARGER_CONFIG_PROTECT_REGS_VH
`define ADDR_CHARGE_VOLTAGE_CONFIG 8'hBB
`define ADDR_WATCHDOG_PROTECT_CTRL 8'hBD
`define ADDR_THERMAL_REG_CONFIG 8'hBE
`define RST_CHARGE_VOLTAGE_CONFIG 8'h96
`define RST_WATCHDOG_PROTECT_CTRL 8'h00
`define RST_THERMAL_REG_CONFIG 8'h40
`define UNLOCK_KEY_VALUE 2'h3
`define WDOG_CLEAR_VALUE 2'h1
`define UNLOCK_KEY_HI 3
`define UNLOCK_KEY_LO 2
`define WDOG_CLEAR_HI 1
`define WDOG_CLEAR_LO 0
`define TERM_VOLT_HI 5
`define TERM_VOLT_LO 0
`define MIN_SYS_HI 7
`define MIN_SYS_LO 6
`define JT_SETPOINT_HI 6
`define JT_SETPOINT_LO 5
`define TERM_VOLT_MAX_CODE 6'h2B
`define CV_MASK 8'hFF
`define WP_MASK 8'h0F
`define TR_MASK 8'h60
`endif
